// ==== logic/pies_pkg.sv ====
`default_nettype none
package pies_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL = 8'h11;
  localparam logic [7:0] IDX_ONE = 8'h12;
  localparam logic [7:0] IDX_TWO = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CTL = {2'h0, IDX_CTL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ONE = {2'h0, IDX_ONE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TWO = {2'h0, IDX_TWO, 2'h0};

  // field layout of the two event registers and width of the control register
  localparam int FLAG_LSB = 8;
  localparam int FLAG_W   = 8;
  localparam int CTL_W    = 4;

  localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
  localparam logic [FLAG_W-1:0] ENAB_RST = 8'h00;
  localparam logic [CTL_W-1:0]  CTL_RST  = 4'h8;

  // control bits: [3] polarity, [2] test, [1] global enable, [0] pin output enable
  typedef struct packed {
    logic pol;
    logic test;
    logic ie;
    logic oe;
  } pies_ctl_t;

  typedef struct packed {
    logic link_qual;
    logic energy;
    logic link;
    logic speed;
    logic duplex;
    logic an_done;
    logic fc_half;
    logic re_half;
    logic eee_err;
    logic an_err;
    logic page_rx;
    logic lb_fifo;
    logic mdix_chg;
    logic sleep;
    logic pol_chg;
    logic wol_pkt;
    logic jabber;
  } pies_evt_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CTL,
    SEL_ONE,
    SEL_TWO
  } pies_sel_t;

  typedef struct packed {
    logic [FLAG_W-1:0] status_one;
    logic [FLAG_W-1:0] enab_one;
    logic [FLAG_W-1:0] status_two;
    logic [FLAG_W-1:0] enab_two;
    pies_ctl_t         ctl;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              pin_o;
    logic              pin_oe;
    logic              pwr_dn;
  } pies_st_t;

  localparam pies_st_t ST_RST = '{
    status_one: FLAG_RST,
    enab_one:   ENAB_RST,
    status_two: FLAG_RST,
    enab_two:   ENAB_RST,
    ctl:        pies_ctl_t'(CTL_RST),
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     32'h0000_0000,
    pin_o:      1'b1,
    pin_oe:     1'b0,
    pwr_dn:     1'b0
  };

endpackage : pies_pkg
`default_nettype wire

// ==== logic/pies_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pies_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output var  logic dout
);

  logic meta_q;

  // pin idles high, so both stages reset high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : pies_sync
`default_nettype wire

// ==== logic/pies_top.sv ====
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pies_top
  import pies_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic [DATA_W-1:0] prdata,
  input  wire pies_evt_t         evt,
  input  wire logic              link_up,
  input  wire logic              pin_i,
  output var  logic              pin_o,
  output var  logic              pin_oe,
  output var  logic              powerdown_req
);

  function automatic pies_sel_t pies_dec(input logic [ADDR_W-1:0] a);
    pies_sel_t s;
    s = SEL_NONE;
    if (a == ADDR_CTL) begin
      s = SEL_CTL;
    end else if (a == ADDR_ONE) begin
      s = SEL_ONE;
    end else if (a == ADDR_TWO) begin
      s = SEL_TWO;
    end
    return s;
  endfunction : pies_dec

  pies_st_t          st_q;
  pies_st_t          st_d;
  logic              pin_sync;
  logic [FLAG_W-1:0] set_one;
  logic [FLAG_W-1:0] set_two;
  logic [FLAG_W-1:0] clr_one;
  logic [FLAG_W-1:0] clr_two;
  logic              acc;
  logic              done;
  logic              irq;
  pies_sel_t         sel;

  pies_sync u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (pin_i),
    .dout   (pin_sync)
  );

  always_comb begin
    st_d = st_q;
    sel  = pies_dec(paddr);
    acc  = psel & penable;
    done = acc & st_q.pready;

    set_one    = 8'h00;
    set_one[7] = evt.link_qual & link_up;
    set_one[6] = evt.energy;
    set_one[5] = evt.link;
    set_one[4] = evt.speed;
    set_one[3] = evt.duplex;
    set_one[2] = evt.an_done;
    set_one[1] = evt.fc_half;
    set_one[0] = evt.re_half;

    set_two    = 8'h00;
    set_two[7] = evt.eee_err;
    set_two[6] = evt.an_err;
    set_two[5] = evt.page_rx;
    set_two[4] = evt.lb_fifo;
    set_two[3] = evt.mdix_chg;
    set_two[2] = evt.sleep;
    set_two[1] = evt.pol_chg | evt.wol_pkt;
    set_two[0] = evt.jabber;

    // clear only what the reader actually saw; later events survive the read
    clr_one = 8'h00;
    clr_two = 8'h00;
    if (done && !pwrite && sel == SEL_ONE) begin
      clr_one = st_q.prdata[FLAG_LSB +: FLAG_W];
    end
    if (done && !pwrite && sel == SEL_TWO) begin
      clr_two = st_q.prdata[FLAG_LSB +: FLAG_W];
    end
    st_d.status_one = (st_q.status_one & ~clr_one) | set_one;
    st_d.status_two = (st_q.status_two & ~clr_two) | set_two;

    // one wait state: read data is snapshot in the first access cycle
    st_d.pready = acc & ~st_q.pready;
    if (acc && !st_q.pready) begin
      st_d.pslverr = (sel == SEL_NONE);
      st_d.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (sel)
          SEL_CTL: st_d.prdata = {28'h000_0000, st_q.ctl};
          SEL_ONE: st_d.prdata = {16'h0000, st_q.status_one, st_q.enab_one};
          SEL_TWO: st_d.prdata = {16'h0000, st_q.status_two, st_q.enab_two};
          default: st_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    if (done && pwrite) begin
      case (sel)
        SEL_CTL: st_d.ctl      = pies_ctl_t'(pwdata[CTL_W-1:0]);
        SEL_ONE: st_d.enab_one = pwdata[FLAG_W-1:0];
        SEL_TWO: st_d.enab_two = pwdata[FLAG_W-1:0];
        default: st_d.ctl      = st_q.ctl;
      endcase
    end

    irq = st_q.ctl.test
        | (st_q.ctl.ie
           & ((|(st_q.status_one & st_q.enab_one))
              | (|(st_q.status_two & st_q.enab_two))));
    st_d.pin_oe = st_q.ctl.oe;
    st_d.pin_o  = st_q.ctl.pol ? ~irq : irq;
    // pin is an active-low powerdown request only while not driven
    st_d.pwr_dn = ~st_q.ctl.oe & ~pin_sync;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    pready        = st_q.pready;
    pslverr       = st_q.pslverr;
    prdata        = st_q.prdata;
    pin_o         = st_q.pin_o;
    pin_oe        = st_q.pin_oe;
    powerdown_req = st_q.pwr_dn;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_lq_gate: assert property (
    (!link_up && !st_q.status_one[7] && !done) |=> !st_q.status_one[7])
    else $error("link quality flag set while link down");

  a_latch_one: assert property (
    (set_one != 8'h00) |=> ((st_q.status_one & $past(set_one)) == $past(set_one)))
    else $error("event lost in register one");

  a_latch_two: assert property (
    (evt.wol_pkt || evt.pol_chg) |=> st_q.status_two[1])
    else $error("shared flag not set");

  a_read_clear: assert property (
    (done && !pwrite && sel == SEL_ONE && set_one == 8'h00)
    |=> ((st_q.status_one & $past(st_q.prdata[15:8])) == 8'h00))
    else $error("read did not clear reported flags");

  a_flag_hold: assert property (
    (!done && set_two == 8'h00) |=> (st_q.status_two == $past(st_q.status_two)))
    else $error("flag changed without read or event");

  a_enab_one: assert property (
    (done && pwrite && sel == SEL_ONE) |=> (st_q.enab_one == $past(pwdata[7:0])))
    else $error("enable write to register one lost");

  a_enab_two: assert property (
    (done && pwrite && sel == SEL_TWO) |=> (st_q.enab_two == $past(pwdata[7:0])))
    else $error("enable write to register two lost");

  a_gate_off: assert property (
    (st_q.ctl.oe && !st_q.ctl.ie && !st_q.ctl.test) |=> (pin_o == $past(st_q.ctl.pol)))
    else $error("interrupt without global enable");

  a_test_irq: assert property (
    (st_q.ctl.test) |=> (pin_o == !$past(st_q.ctl.pol)))
    else $error("test interrupt not driven");

  a_irq_any: assert property (
    (st_q.ctl.ie && (st_q.status_one & st_q.enab_one) != 8'h00)
    |=> (pin_o == !$past(st_q.ctl.pol)))
    else $error("enabled flag gave no interrupt");

  a_pin_dir: assert property (
    (!st_q.ctl.oe) |=> (!pin_oe ##1 !pin_oe || st_q.ctl.oe))
    else $error("pin driven while used as input");

  a_apb_wait: assert property (
    (acc && !pready) |=> pready)
    else $error("access not answered in one wait state");

  // one check per event source; an event always beats a clearing read
  a_lq_set: assert property (
    (evt.link_qual && link_up) |=> st_q.status_one[7])
    else $error("link quality flag not set");

  a_energy_set: assert property (
    evt.energy |=> st_q.status_one[6])
    else $error("energy detect flag not set");

  a_link_set: assert property (
    evt.link |=> st_q.status_one[5])
    else $error("link status flag not set");

  a_speed_set: assert property (
    evt.speed |=> st_q.status_one[4])
    else $error("speed flag not set");

  a_duplex_set: assert property (
    evt.duplex |=> st_q.status_one[3])
    else $error("duplex flag not set");

  a_autoneg_set: assert property (
    evt.an_done |=> st_q.status_one[2])
    else $error("negotiation done flag not set");

  a_fc_set: assert property (
    evt.fc_half |=> st_q.status_one[1])
    else $error("false carrier flag not set");

  a_rxerr_set: assert property (
    evt.re_half |=> st_q.status_one[0])
    else $error("receive error flag not set");

  a_eee_set: assert property (
    evt.eee_err |=> st_q.status_two[7])
    else $error("eee error flag not set");

  a_anerr_set: assert property (
    evt.an_err |=> st_q.status_two[6])
    else $error("negotiation error flag not set");

  a_page_set: assert property (
    evt.page_rx |=> st_q.status_two[5])
    else $error("page received flag not set");

  a_fifo_set: assert property (
    evt.lb_fifo |=> st_q.status_two[4])
    else $error("loopback fifo flag not set");

  a_mdix_set: assert property (
    evt.mdix_chg |=> st_q.status_two[3])
    else $error("crossover flag not set");

  a_sleep_set: assert property (
    evt.sleep |=> st_q.status_two[2])
    else $error("sleep flag not set");

  a_pol_set: assert property (
    evt.pol_chg |=> st_q.status_two[1])
    else $error("polarity change did not set shared flag");

  a_wol_set: assert property (
    evt.wol_pkt |=> st_q.status_two[1])
    else $error("wake packet did not set shared flag");

  a_jabber_set: assert property (
    evt.jabber |=> st_q.status_two[0])
    else $error("jabber flag not set");

  a_pin_two: assert property (
    (st_q.ctl.pol && st_q.ctl.ie && (st_q.status_two & st_q.enab_two) != 8'h00)
    |=> !pin_o)
    else $error("enabled flag of register two gave no interrupt");

  a_hold_one: assert property (
    (!done && set_one == 8'h00) |=> (st_q.status_one == $past(st_q.status_one)))
    else $error("flag of register one changed without read or event");

  a_clear_two: assert property (
    (done && !pwrite && sel == SEL_TWO && set_two == 8'h00)
    |=> ((st_q.status_two & $past(st_q.prdata[15:8])) == 8'h00))
    else $error("read did not clear reported flags of register two");

  a_enab_hold: assert property (
    !(done && pwrite)
    |=> (st_q.enab_one == $past(st_q.enab_one) && st_q.enab_two == $past(st_q.enab_two)))
    else $error("enable bits changed without a write");

  a_ctl_write: assert property (
    (done && pwrite && sel == SEL_CTL) |=> (st_q.ctl == $past(pwdata[CTL_W-1:0])))
    else $error("control write lost");

  a_read_one: assert property (
    (acc && !pready && !pwrite && sel == SEL_ONE)
    |=> (prdata == {16'h0000, $past(st_q.status_one), $past(st_q.enab_one)}))
    else $error("register one read data wrong");

  a_oe_on: assert property (
    st_q.ctl.oe |=> pin_oe)
    else $error("pin not driven as interrupt output");

  a_powerdown: assert property (
    (!st_q.ctl.oe && !pin_sync) |=> powerdown_req)
    else $error("powerdown request missing");

  // bus answer: one cycle of pready, error only for unmapped addresses
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_bad_addr: assert property (
    (acc && !pready && sel == SEL_NONE) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  a_good_addr: assert property (
    (acc && !pready && sel != SEL_NONE) |=> !pslverr)
    else $error("mapped access flagged as error");

  c_read_clear: cover property (done && !pwrite && sel == SEL_ONE && st_q.prdata[15:8] != 8'h00);
  c_test_irq: cover property (st_q.ctl.oe && st_q.ctl.test ##1 pin_o == !st_q.ctl.pol);
  c_event_irq: cover property (st_q.ctl.ie && (st_q.status_two & st_q.enab_two) != 8'h00);
  c_powerdown: cover property (powerdown_req);
  c_read_two: cover property (
    done && !pwrite && sel == SEL_TWO && st_q.prdata[15:8] != 8'h00);

endmodule : pies_top
`default_nettype wire

// ==== verification/pies_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pies_host (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic hold_low,
  output var  logic pin_level
);
  // pin is pulled up; the host pulls it low only to request power-down
  always_comb begin
    pin_level = pin_oe ? pin_o : ~hold_low;
  end
endmodule : pies_host
`default_nettype wire

// ==== verification/pies_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pies_top_tb_top;
  import pies_pkg::*;
  logic              clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic              pready;
  logic              pslverr;
  logic [DATA_W-1:0] prdata;
  pies_evt_t         evt;
  logic              link_up;
  logic              hold_low;
  logic              pin_level;
  logic              pin_o;
  logic              pin_oe;
  logic              powerdown_req;
  int                miscompares;
  int                check_count;
  int                cycles = 0;
  logic [31:0]       rd;
  logic              err;

  pies_top i_pies_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .evt(evt), .link_up(link_up), .pin_i(pin_level), .pin_o(pin_o),
    .pin_oe(pin_oe), .powerdown_req(powerdown_req));
  pies_host i_pies_host (.pin_o(pin_o), .pin_oe(pin_oe), .hold_low(hold_low),
    .pin_level(pin_level));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // the watchdog caps the whole run at 20000 cycles; the full run of all tests is far shorter
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic [16:0] v);
    @(posedge clk);
    evt <= pies_evt_t'(v);
    @(posedge clk);
    evt <= '0;
  endtask : pulse

  task automatic pin_chk(input logic o, input logic oe);
    repeat (3) @(posedge clk);
    chk(32'(pin_o), 32'(o));
    chk(32'(pin_oe), 32'(oe));
  endtask : pin_chk

  task automatic t_reset();
    chk(32'(pin_o), 32'h1);
    chk(32'(pin_oe), 32'h0);
    apb(1'b0, ADDR_CTL, '0);
    chk(rd, 32'h0000_0008);
    apb(1'b0, ADDR_ONE, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, ADDR_TWO, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h0F0, '0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_flags();
    int k;
    int pos;
    link_up <= 1'b0;
    pulse(17'h1_0000);
    apb(1'b0, ADDR_ONE, '0);
    chk(rd, 32'h0);
    link_up <= 1'b1;
    for (k = 0; k < 17; k++) begin
      pos = (k < 8) ? 15 - k : (k < 14) ? 23 - k : (k < 16) ? 9 : 8;
      pulse(17'h1_0000 >> k);
      apb(1'b0, (k < 8) ? ADDR_ONE : ADDR_TWO, '0);
      if (k < 8) chk(rd, 32'h1 << pos);
      else chk(rd, 32'h1 << pos);
      apb(1'b0, (k < 8) ? ADDR_ONE : ADDR_TWO, '0);
      chk(rd, 32'h0);
    end
  endtask : t_flags

  task automatic t_enables();
    apb(1'b1, ADDR_ONE, 32'hFFFF_00A5);
    apb(1'b0, ADDR_ONE, '0);
    chk(rd, 32'h0000_00A5);
    apb(1'b1, ADDR_TWO, 32'h0000_005A);
    apb(1'b0, ADDR_TWO, '0);
    chk(rd, 32'h0000_005A);
  endtask : t_enables

  task automatic t_irq();
    apb(1'b1, ADDR_CTL, 32'h9);
    pulse(17'h0_4000);
    pin_chk(1'b1, 1'b1);
    apb(1'b1, ADDR_CTL, 32'hB);
    pin_chk(1'b0, 1'b1);
    apb(1'b0, ADDR_ONE, '0);
    chk(rd, 32'h0000_20A5);
    pin_chk(1'b1, 1'b1);
    pulse(17'h0_2000);
    pin_chk(1'b1, 1'b1);
    apb(1'b0, ADDR_ONE, '0);
    apb(1'b1, ADDR_CTL, 32'h3);
    pulse(17'h0_4000);
    pin_chk(1'b1, 1'b1);
    apb(1'b0, ADDR_ONE, '0);
    apb(1'b1, ADDR_CTL, 32'hD);
    pin_chk(1'b0, 1'b1);
    apb(1'b1, ADDR_CTL, 32'h5);
    pin_chk(1'b1, 1'b1);
    apb(1'b1, ADDR_CTL, 32'hB);
    pulse(17'h0_0002);
    pin_chk(1'b0, 1'b1);
    apb(1'b0, ADDR_TWO, '0);
    chk(rd, 32'h0000_025A);
    pin_chk(1'b1, 1'b1);
  endtask : t_irq

  task automatic t_powerdown();
    apb(1'b1, ADDR_CTL, 32'h8);
    hold_low <= 1'b1;
    pin_chk(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(powerdown_req), 32'h1);
    hold_low <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(powerdown_req), 32'h0);
  endtask : t_powerdown

  // reset in mid-run must bring back the defaults and drop pending flags
  task automatic t_midreset();
    apb(1'b1, ADDR_ONE, 32'h0000_00FF);
    apb(1'b1, ADDR_CTL, 32'h0000_0007);
    pulse(17'h1_0000);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk(32'(pin_oe), 32'h0);
    chk(32'(pin_o), 32'h1);
    apb(1'b0, ADDR_CTL, '0);
    chk(rd, 32'h0000_0008);
    apb(1'b0, ADDR_ONE, '0);
    chk(rd, 32'h0000_0000);
  endtask : t_midreset

  initial begin
    miscompares = 0;
    check_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    evt = '0;
    link_up = 1'b1;
    hold_low = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_flags();
    t_enables();
    t_irq();
    t_powerdown();
    t_midreset();
    final_report();
  end
endmodule : pies_top_tb_top
`default_nettype wire
